// ==== core/rsw_pkg.sv ====
// rsw_pkg: constants for the remote switch and switch bank block
// assumes one 250 MHz system clock and a plain register port
package rsw_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_HZ           = 250_000_000;
    localparam int PULSE_MS         = 100;
    localparam int PULSE_CYC        = CLK_HZ / 1000 * PULSE_MS;
    localparam int STATUS_PERIOD_MS = 1000;
    localparam int STATUS_CYC       = CLK_HZ / 1000 * STATUS_PERIOD_MS;
    localparam int CNT_W            = 28;

    // ==========================================================
    // channels, buttons, switch bank
    localparam int NUM_CH      = 3;
    localparam int NUM_BTN     = 19;
    localparam int NUM_IDX     = 28;
    localparam int POWER_BTN   = 9;
    localparam logic [4:0] IDX_GAP     = 5'h0a;
    localparam logic [4:0] IDX_LAST_HI = 5'h13;
    localparam logic [7:0] BANK_INST   = 8'h28;
    localparam logic [16:0] PGN_STATUS  = 17'h1f20d;
    localparam logic [16:0] PGN_CONTROL = 17'h1f20e;

    // switch state codes
    localparam logic [1:0] SW_OFF   = 2'h0;
    localparam logic [1:0] SW_ON    = 2'h1;
    localparam logic [1:0] SW_ERROR = 2'h2;
    localparam logic [1:0] SW_NA    = 2'h3;

    // ==========================================================
    // register map
    localparam logic [7:0] REG_CFG    = 8'h00;
    localparam logic [7:0] REG_CHSEL  = 8'h04;
    localparam logic [7:0] REG_NETEN  = 8'h08;
    localparam logic [7:0] REG_BTN    = 8'h0c;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // cfg fields
    localparam int CFG_MODE_POS = 0;
    localparam int CFG_POL_POS  = 4;

    // chsel fields, 5 bits per channel, 8 bits apart
    localparam int CHSEL_STRIDE = 8;
    localparam int CHSEL_W      = 5;

    // status fields
    localparam int ST_CLOSED_POS = 0;
    localparam int ST_ON_POS     = 4;
    localparam int ST_OFF_POS    = 8;
    localparam int ST_BUSY_POS   = 12;
    localparam int ST_MISM_POS   = 16;

    // reset values
    localparam logic [31:0] CFG_RST   = 32'h0000_0000;
    localparam logic [31:0] CHSEL_RST = 32'h0002_0100;
    localparam logic [18:0] NETEN_RST = 19'h7fdff;

endpackage

// ==== core/rsw_channel.sv ====
// rsw_channel: one remote switch channel, drive and state return
// assumes btn_state comes from logic on clk_sys, the return pin does not
`timescale 1ns/100ps

module rsw_channel
    import rsw_pkg::*;
#(
    parameter int PULSE_CYC_P = PULSE_CYC
)
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic mode_pulse,
    input  wire logic fb_high,
    input  wire logic btn_state,
    input  wire logic state_return_input,
    output logic      on_out,
    output logic      off_out,
    output logic      closed,
    output logic      busy
);

    typedef enum logic [1:0] {S_IDLE, S_PULSE_ON, S_PULSE_OFF, S_GAP}
        rsw_pulse_type;

    rsw_pulse_type     st_r;
    logic              prev_r;
    logic [CNT_W-1:0]  cnt_r;
    logic              fb_meta_r;
    logic              fb_sync_r;
    logic              change;

    assign change = btn_state != prev_r;
    assign busy   = st_r != S_IDLE;

    // ==========================================================
    // state return input, two flops then polarity
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            fb_meta_r <= 1'b0;
            fb_sync_r <= 1'b0;
        end
        else
        begin
            fb_meta_r <= state_return_input;
            fb_sync_r <= fb_meta_r;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            closed <= 1'b0;
        else
            closed <= fb_high ? fb_sync_r : ~fb_sync_r;
    end

    // ==========================================================
    // change detect, no pulse out of reset
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            prev_r <= 1'b0;
        else
            prev_r <= btn_state;
    end

    // ==========================================================
    // pulse sequencer
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            st_r  <= S_IDLE;
            cnt_r <= '0;
        end
        else if (!mode_pulse)
        begin
            st_r  <= S_IDLE;
            cnt_r <= '0;
        end
        else
        begin
            case (st_r)
                S_IDLE:
                begin
                    cnt_r <= '0;
                    if (change)
                        st_r <= btn_state ? S_PULSE_ON : S_PULSE_OFF;
                end
                S_PULSE_ON, S_PULSE_OFF:
                begin
                    cnt_r <= cnt_r + 1'b1;
                    if (change)
                    begin
                        st_r  <= S_GAP;
                        cnt_r <= '0;
                    end
                    else if (cnt_r == CNT_W'(PULSE_CYC_P - 1))
                        st_r <= S_IDLE;
                end
                S_GAP:
                begin
                    cnt_r <= '0;
                    st_r  <= btn_state ? S_PULSE_ON : S_PULSE_OFF;
                end
                default:
                    st_r <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // output drive
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            on_out  <= 1'b0;
            off_out <= 1'b0;
        end
        else if (!mode_pulse)
        begin
            on_out  <= btn_state;
            off_out <= ~btn_state;
        end
        else
        begin
            on_out  <= st_r == S_PULSE_ON;
            off_out <= st_r == S_PULSE_OFF;
        end
    end

    // ==========================================================
    // assertions
    property p_level_on;
        @(posedge clk_sys) disable iff (rst)
        !mode_pulse && $past(!mode_pulse) && btn_state |=> on_out;
    endproperty
    a_level_on: assert property (p_level_on)
        else $error("level mode on output not held");

    property p_level_off;
        @(posedge clk_sys) disable iff (rst)
        !mode_pulse && $past(!mode_pulse) && !btn_state |=> off_out && !on_out;
    endproperty
    a_level_off: assert property (p_level_off)
        else $error("level mode off output not held");

    property p_pulse_start;
        @(posedge clk_sys) disable iff (rst)
        mode_pulse && st_r == S_IDLE && change && btn_state
            ##1 mode_pulse |=> on_out;
    endproperty
    a_pulse_start: assert property (p_pulse_start)
        else $error("on pulse did not start");

    property p_pulse_off_start;
        @(posedge clk_sys) disable iff (rst)
        mode_pulse && st_r == S_IDLE && change && !btn_state
            ##1 mode_pulse |=> off_out;
    endproperty
    a_pulse_off_start: assert property (p_pulse_off_start)
        else $error("off pulse did not start");

    property p_pulse_len;
        @(posedge clk_sys) disable iff (rst)
        busy |-> cnt_r < CNT_W'(PULSE_CYC_P);
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("pulse counter overran");

    property p_never_both;
        @(posedge clk_sys) disable iff (rst)
        !(on_out && off_out);
    endproperty
    a_never_both: assert property (p_never_both)
        else $error("on and off outputs both active");

    property p_polarity;
        @(posedge clk_sys) disable iff (rst)
        $stable(fb_high) |=> closed == ($past(fb_high) ~^ $past(fb_sync_r));
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("state return polarity wrong");

endmodule

// ==== core/rsw_top.sv ====
// rsw_top: remote switch channels and network switch bank
// assumes panel button events and the network frame layer on clk_sys
// assumes the three return pins are asynchronous
//
// What this block does
// - three remote channels, on, off, return input
// - per channel level or pulse mode select
// - level mode holds on while button on
// - level mode holds off while button off
// - pulse mode: 100 ms on pulse at on
// - pulse mode: 100 ms off pulse at off
// - return input sampled to closed state
// - low polarity: low return means closed
// - high polarity: high return means closed
// - accept control messages, never send them
// - send status periodically, ignore received status
// - each mapped index reported on, off or error, unused indexes not available
// - bank instance 40; other instances ignored
// - indexes 1 to 28, shared numbering
// - indexes 10, 20 to 28 unused
// - power button never network controlled
// - all mapped buttons network enabled after reset
// - button n maps to switch n+1
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/100ps

module rsw_top
    import rsw_pkg::*;
#(
    parameter int PULSE_CYC_P  = PULSE_CYC,
    parameter int STATUS_CYC_P = STATUS_CYC
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [18:0] btn_press,
    input  wire logic [18:0] btn_fault,
    output logic      [18:0] btn_state,
    input  wire logic        cmd_valid,
    input  wire logic [16:0] cmd_pgn,
    input  wire logic [7:0]  cmd_instance,
    input  wire logic [4:0]  cmd_index,
    input  wire logic [1:0]  cmd_state,
    output logic             stat_valid,
    input  wire logic        stat_ready,
    output logic      [16:0] stat_pgn,
    output logic      [7:0]  stat_instance,
    output logic      [55:0] stat_states,
    output logic      [2:0]  sw_on,
    output logic      [2:0]  sw_off,
    input  wire logic [2:0]  state_return_input
);

    // ==========================================================
    // index mapping
    function automatic logic idx_mapped(input logic [4:0] idx);
        idx_mapped = (idx != 5'h00) && (idx != IDX_GAP)
                     && (idx <= IDX_LAST_HI);
    endfunction

    function automatic logic [4:0] idx_to_btn(input logic [4:0] idx);
        idx_to_btn = idx - 5'h01;
    endfunction

    // ==========================================================
    // registers
    logic [31:0]       cfg_r;
    logic [31:0]       chsel_r;
    logic [18:0]       neten_r;
    logic [18:0]       btn_r;
    logic [CNT_W-1:0]  per_cnt_r;
    logic              stat_valid_r;
    logic [55:0]       stat_states_r;
    logic [31:0]       rdata_r;
    logic [55:0]       snap;
    logic [2:0]        closed;
    logic [2:0]        busy;
    logic [2:0]        mismatch;
    logic [18:0]       ch_fault;
    logic [4:0]        ch_btn [NUM_CH];
    logic              cmd_hit;
    logic [4:0]        cmd_btn;
    logic [31:0]       status_word;

    assign btn_state     = btn_r;
    assign stat_valid    = stat_valid_r;
    assign stat_states   = stat_states_r;
    assign stat_pgn      = PGN_STATUS;
    assign stat_instance = BANK_INST;
    assign reg_rdata     = rdata_r;

    // ==========================================================
    // control message acceptance
    assign cmd_btn = idx_to_btn(cmd_index);
    assign cmd_hit = cmd_valid
                     && cmd_pgn == PGN_CONTROL
                     && cmd_instance == BANK_INST
                     && idx_mapped(cmd_index)
                     && cmd_btn != 5'(POWER_BTN)
                     && neten_r[cmd_btn]
                     && (cmd_state == SW_OFF || cmd_state == SW_ON);

    // ==========================================================
    // button states, panel press toggles, command sets
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            btn_r <= '0;
        else
        begin
            for (int b = 0; b < NUM_BTN; b++)
            begin
                if (btn_press[b])
                    btn_r[b] <= ~btn_r[b];
                else if (cmd_hit && cmd_btn == 5'(b))
                    btn_r[b] <= cmd_state == SW_ON;
            end
        end
    end

    // ==========================================================
    // register writes
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            cfg_r   <= CFG_RST;
            chsel_r <= CHSEL_RST;
            neten_r <= NETEN_RST;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                REG_CFG:   cfg_r   <= reg_wdata;
                REG_CHSEL: chsel_r <= reg_wdata;
                REG_NETEN: neten_r <= reg_wdata[18:0] & NETEN_RST;
                default:   ;
            endcase
        end
    end

    // ==========================================================
    // register reads, data one cycle after the strobe
    always_comb
    begin
        status_word = '0;
        status_word[ST_CLOSED_POS +: NUM_CH] = closed;
        status_word[ST_ON_POS     +: NUM_CH] = sw_on;
        status_word[ST_OFF_POS    +: NUM_CH] = sw_off;
        status_word[ST_BUSY_POS   +: NUM_CH] = busy;
        status_word[ST_MISM_POS   +: NUM_CH] = mismatch;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            rdata_r <= '0;
        else if (reg_rd)
        begin
            case (reg_addr)
                REG_CFG:    rdata_r <= cfg_r;
                REG_CHSEL:  rdata_r <= chsel_r;
                REG_NETEN:  rdata_r <= {13'h0000, neten_r};
                REG_BTN:    rdata_r <= {13'h0000, btn_r};
                REG_STATUS: rdata_r <= status_word;
                default:    rdata_r <= '0;
            endcase
        end
        else
            rdata_r <= '0;
    end

    // ==========================================================
    // remote switch channels
    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++)
        begin : g_ch
            logic sel_ok;
            logic sel_state;

            assign ch_btn[c]  = chsel_r[c*CHSEL_STRIDE +: CHSEL_W];
            assign sel_ok     = ch_btn[c] < 5'(NUM_BTN);
            assign sel_state  = sel_ok ? btn_r[ch_btn[c]] : 1'b0;
            assign mismatch[c] = sel_ok && !busy[c]
                                 && (closed[c] != sel_state);

            rsw_channel #(
                .PULSE_CYC_P (PULSE_CYC_P)
            ) u_ch (
                .clk_sys            (clk_sys),
                .rst                (rst),
                .mode_pulse         (cfg_r[CFG_MODE_POS + c]),
                .fb_high            (cfg_r[CFG_POL_POS + c]),
                .btn_state          (sel_state),
                .state_return_input (state_return_input[c]),
                .on_out             (sw_on[c]),
                .off_out            (sw_off[c]),
                .closed             (closed[c]),
                .busy               (busy[c])
            );
        end
    endgenerate

    // fault per button from a disagreeing channel
    always_comb
    begin
        ch_fault = '0;
        for (int k = 0; k < NUM_CH; k++)
        begin
            if (mismatch[k])
                ch_fault[ch_btn[k]] = 1'b1;
        end
    end

    // ==========================================================
    // status snapshot, two bits per index 1 to 28
    always_comb
    begin
        snap = '0;
        for (int i = 1; i <= NUM_IDX; i++)
        begin
            if (!idx_mapped(5'(i)))
                snap[(i-1)*2 +: 2] = SW_NA;
            else if (btn_fault[i-1] || ch_fault[i-1])
                snap[(i-1)*2 +: 2] = SW_ERROR;
            else if (btn_r[i-1])
                snap[(i-1)*2 +: 2] = SW_ON;
            else
                snap[(i-1)*2 +: 2] = SW_OFF;
        end
    end

    // ==========================================================
    // periodic status transmit
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            per_cnt_r     <= '0;
            stat_valid_r  <= 1'b0;
            stat_states_r <= '0;
        end
        else
        begin
            if (stat_valid_r && stat_ready)
                stat_valid_r <= 1'b0;
            if (per_cnt_r == CNT_W'(STATUS_CYC_P - 1))
            begin
                per_cnt_r <= '0;
                if (!stat_valid_r || stat_ready)
                begin
                    stat_valid_r  <= 1'b1;
                    stat_states_r <= snap;
                end
            end
            else
                per_cnt_r <= per_cnt_r + 1'b1;
        end
    end

    // ==========================================================
    // assertions
    property p_power_fixed;
        @(posedge clk_sys) disable iff (rst)
        !btn_press[POWER_BTN] |=> $stable(btn_r[POWER_BTN]);
    endproperty
    a_power_fixed: assert property (p_power_fixed)
        else $error("power button changed without a press");

    property p_foreign_inst;
        @(posedge clk_sys) disable iff (rst)
        cmd_valid && cmd_instance != BANK_INST && btn_press == '0
            |=> $stable(btn_r);
    endproperty
    a_foreign_inst: assert property (p_foreign_inst)
        else $error("command for another instance acted on");

    property p_unused_idx;
        @(posedge clk_sys) disable iff (rst)
        cmd_valid && !idx_mapped(cmd_index) && btn_press == '0
            |=> $stable(btn_r);
    endproperty
    a_unused_idx: assert property (p_unused_idx)
        else $error("command to unused index changed a button");

    property p_status_rx_ignored;
        @(posedge clk_sys) disable iff (rst)
        cmd_valid && cmd_pgn == PGN_STATUS && btn_press == '0
            |=> $stable(btn_r);
    endproperty
    a_status_rx_ignored: assert property (p_status_rx_ignored)
        else $error("received status message acted on");

    property p_cmd_map;
        @(posedge clk_sys) disable iff (rst)
        cmd_hit && !btn_press[cmd_btn]
            |=> btn_r[$past(cmd_index) - 5'h01] == $past(cmd_state[0]);
    endproperty
    a_cmd_map: assert property (p_cmd_map)
        else $error("command applied to wrong button");

    property p_neten_reset;
        @(posedge clk_sys)
        $fell(rst) |-> neten_r == NETEN_RST;
    endproperty
    a_neten_reset: assert property (p_neten_reset)
        else $error("network enable not set after reset");

    property p_status_hold;
        @(posedge clk_sys) disable iff (rst)
        stat_valid_r && !stat_ready |=> stat_valid_r && $stable(stat_states_r);
    endproperty
    a_status_hold: assert property (p_status_hold)
        else $error("status dropped before accepted");

    property p_unused_na;
        @(posedge clk_sys) disable iff (rst)
        stat_valid_r |-> stat_states_r[19:18] == SW_NA
                         && stat_states_r[55:54] == SW_NA;
    endproperty
    a_unused_na: assert property (p_unused_na)
        else $error("unused index not reported unavailable");

    property p_status_taken;
        @(posedge clk_sys) disable iff (rst)
        stat_valid_r && stat_ready
            && per_cnt_r != CNT_W'(STATUS_CYC_P - 1) |=> !stat_valid_r;
    endproperty
    a_status_taken: assert property (p_status_taken)
        else $error("status held after accepted");

    property p_neten_power;
        @(posedge clk_sys) disable iff (rst)
        !neten_r[POWER_BTN];
    endproperty
    a_neten_power: assert property (p_neten_power)
        else $error("power button network enabled");

endmodule

// ==== verif/rsw_remote_model.sv ====
// rsw_remote_model: three latching remote switches with state return
// assumes on/off drive from the block, return polarity picked by bench
`timescale 1ns/100ps

module rsw_remote_model
(
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic [2:0] drv_on,
    input  wire logic [2:0] drv_off,
    input  wire logic [2:0] ret_high,
    output logic      [2:0] ret_pin
);
    // ==========================================================
    // contacts: closed by on drive, opened by off drive
    logic [2:0] shut_r;

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
            shut_r <= 3'h0;
        else
            shut_r <= (shut_r | drv_on) & ~drv_off;
    end

    // return pin level per polarity pick
    assign ret_pin = shut_r ^ ~ret_high;

endmodule

// ==== verif/remote_switch_and_switch_bank_bench.sv ====
// remote_switch_and_switch_bank_bench: self-checking bench for rsw_top
// assumes rsw_pkg, rsw_top and rsw_remote_model are compiled first
`timescale 1ns/100ps

module remote_switch_and_switch_bank_bench
    import rsw_pkg::*;
;
    // ==========================================================
    // signals
    typedef struct packed
    {
        logic [16:0] p;
        logic [7:0]  i;
        logic [4:0]  x;
        logic [1:0]  s;
        logic [18:0] e;
    } rsw_row_type;

    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [18:0] btn_press = 19'h0;
    logic [18:0] btn_fault = 19'h0;
    logic [18:0] btn_state;
    logic        cmd_valid = 1'b0;
    logic [16:0] cmd_pgn = 17'h0;
    logic [7:0]  cmd_instance = 8'h00;
    logic [4:0]  cmd_index = 5'h00;
    logic [1:0]  cmd_state = 2'h0;
    logic        stat_valid;
    logic        stat_ready = 1'b1;
    logic [16:0] stat_pgn;
    logic [7:0]  stat_instance;
    logic [55:0] stat_states;
    logic [2:0]  sw_on;
    logic [2:0]  sw_off;
    logic [2:0]  ret_pin;
    logic [2:0]  ret_high = 3'h0;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          n;

    // ==========================================================
    // command rows: pgn, instance, index, state, expected buttons
    localparam rsw_row_type ROWS [11] = '{
        '{PGN_CONTROL, BANK_INST, 5'h03, 2'h1, 19'h00004},
        '{PGN_STATUS,  BANK_INST, 5'h04, 2'h1, 19'h00004},
        '{PGN_CONTROL, 8'h29,     5'h04, 2'h1, 19'h00004},
        '{PGN_CONTROL, BANK_INST, 5'h0a, 2'h1, 19'h00004},
        '{PGN_CONTROL, BANK_INST, 5'h14, 2'h1, 19'h00004},
        '{PGN_CONTROL, BANK_INST, 5'h1c, 2'h1, 19'h00004},
        '{PGN_CONTROL, BANK_INST, 5'h04, 2'h2, 19'h00004},
        '{PGN_CONTROL, BANK_INST, 5'h0b, 2'h1, 19'h00404},
        '{PGN_CONTROL, BANK_INST, 5'h13, 2'h1, 19'h40404},
        '{PGN_CONTROL, BANK_INST, 5'h01, 2'h1, 19'h40405},
        '{PGN_CONTROL, BANK_INST, 5'h03, 2'h0, 19'h40401}};

    always #2 clk_sys = ~clk_sys;

    rsw_top #(.PULSE_CYC_P(20), .STATUS_CYC_P(50)) i_rsw_top (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .btn_press(btn_press),
        .btn_fault(btn_fault), .btn_state(btn_state),
        .cmd_valid(cmd_valid), .cmd_pgn(cmd_pgn),
        .cmd_instance(cmd_instance), .cmd_index(cmd_index),
        .cmd_state(cmd_state), .stat_valid(stat_valid),
        .stat_ready(stat_ready), .stat_pgn(stat_pgn),
        .stat_instance(stat_instance), .stat_states(stat_states),
        .sw_on(sw_on), .sw_off(sw_off), .state_return_input(ret_pin));

    rsw_remote_model i_rsw_remote_model (
        .clk_sys(clk_sys), .rst(rst), .drv_on(sw_on),
        .drv_off(sw_off), .ret_high(ret_high), .ret_pin(ret_pin));

    // ==========================================================
    // tasks
    task automatic chk_val(input logic [63:0] got, input logic [63:0] e);
        n_tests++;
        if (got !== e)
        begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h", $time, got, e);
        end
    endtask

    task automatic chk_cnt(input int got, input int e);
        chk_val(64'(got), 64'(e));
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic reg_put(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_chk(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk_val(reg_rdata, e);
    endtask

    task automatic send(input rsw_row_type r);
        @(posedge clk_sys);
        cmd_pgn <= r.p;
        cmd_instance <= r.i;
        cmd_index <= r.x;
        cmd_state <= r.s;
        cmd_valid <= 1'b1;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
    endtask

    // high cycles of channel 0 on or off output over a window
    task automatic count_hi(input bit on);
        n = 0;
        repeat (40)
        begin
            @(posedge clk_sys);
            #1;
            n += on ? int'(sw_on[0]) : int'(sw_off[0]);
        end
    endtask

    function automatic logic [55:0] exp_st(input logic [18:0] s, f);
        logic [55:0] r;
        for (int i = 0; i < 28; i++)
            r[2*i +: 2] = (i == 9 || i > 18) ? SW_NA :
                          f[i] ? SW_ERROR : (s[i] ? SW_ON : SW_OFF);
        return r;
    endfunction

    // both outputs of a channel never high together
    always @(posedge clk_sys)
        if (!rst && (sw_on & sw_off) !== 3'h0)
            chk_val(sw_on & sw_off, 64'h0);

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        wrap_up();
    end

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        chk_val(sw_on, 3'h0);
        chk_val(sw_off, 3'h7);
        reg_chk(REG_CFG, 32'h0);
        reg_chk(REG_CHSEL, 32'h0002_0100);
        reg_chk(REG_NETEN, 32'h0007_fdff);
        reg_chk(8'h14, 32'h0);
        foreach (ROWS[k])
        begin
            send(ROWS[k]);
            @(posedge clk_sys);
            #1;
            chk_val(btn_state, ROWS[k].e);
        end
        repeat (8) @(posedge clk_sys);
        #1;
        chk_val({sw_on, sw_off}, 6'h0e);
        reg_chk(REG_STATUS, 32'h0000_0611);
        reg_put(REG_CFG, 32'h70);
        ret_high <= 3'h7;
        repeat (8) @(posedge clk_sys);
        reg_chk(REG_STATUS, 32'h0000_0611);
        reg_put(REG_NETEN, 32'h0007_ffef);
        reg_chk(REG_NETEN, 32'h0007_fdef);
        send('{PGN_CONTROL, BANK_INST, 5'h05, 2'h1, 19'h0});
        @(posedge clk_sys);
        #1;
        chk_val(btn_state, 19'h40401);
        reg_put(REG_NETEN, 32'h0007_fdff);
        reg_put(REG_CFG, 32'h71);
        send('{PGN_CONTROL, BANK_INST, 5'h01, 2'h0, 19'h0});
        count_hi(1'b0);
        chk_cnt(n, 20);
        send('{PGN_CONTROL, BANK_INST, 5'h01, 2'h1, 19'h0});
        count_hi(1'b1);
        chk_cnt(n, 20);
        send('{PGN_CONTROL, BANK_INST, 5'h01, 2'h0, 19'h0});
        repeat (5) @(posedge clk_sys);
        send('{PGN_CONTROL, BANK_INST, 5'h01, 2'h1, 19'h0});
        count_hi(1'b1);
        chk_cnt(n, 20);
        btn_fault <= 19'h00010;
        repeat (120) @(posedge clk_sys);
        stat_ready <= 1'b0;
        #1;
        n = 0;
        while (stat_valid !== 1'b1 && n < 60)
        begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk_val({stat_pgn, stat_instance}, {PGN_STATUS, 8'h28});
        chk_val(stat_states, exp_st(19'h40401, 19'h10));
        repeat (60) @(posedge clk_sys);
        #1;
        chk_val({stat_valid, stat_states},
                {1'b1, exp_st(19'h40401, 19'h10)});
        @(posedge clk_sys);
        btn_press <= 19'h00201;
        @(posedge clk_sys);
        btn_press <= 19'h00000;
        @(posedge clk_sys);
        #1;
        chk_val(btn_state, 19'h40600);
        stat_ready <= 1'b1;
        wrap_up();
    end

endmodule
